// ---- logic/serial_port_zero_consts.vh ----
`ifndef SERIAL_PORT_ZERO_CONSTS_VH
`define SERIAL_PORT_ZERO_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_CONTROL 12'h098
`define IDX_DATA 12'h099
`define IDX_BAUD 12'h09a
`define IDX_CONFIG 12'h09b
`define IDX_IRQ_STATUS 12'h09c
`define IDX_IRQ_MASK 12'h09d
`define ADDR_CONTROL 12'h260
`define ADDR_DATA 12'h264
`define ADDR_BAUD 12'h268
`define ADDR_CONFIG 12'h26c
`define ADDR_IRQ_STATUS 12'h270
`define ADDR_IRQ_MASK 12'h274

// Control register fields
`define CTL_MODE_HI 7
`define CTL_MODE_LO 6
`define CTL_FILTER 5
`define CTL_RX_ALLOW 4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0

// Config register fields
`define CFG_VIEW_SELECT 0
`define CFG_DOUBLE_RATE 1

// Interrupt status fields
`define IRQ_TX 0
`define IRQ_RX 1
`define IRQ_FE 2

// Modes
`define MODE_SYNC 2'b00
`define MODE_ASYNC10 2'b01
`define MODE_ASYNC11_FIXED 2'b10
`define MODE_ASYNC11_VAR 2'b11

// Bit times in clock cycles
`define SYNC_DIV_SLOW 16'h000c
`define SYNC_DIV_FAST 16'h0004
`define FIXED_DIV_SLOW 16'h0040
`define FIXED_DIV_FAST 16'h0020
`define BAUD_DIV_RST 16'h0364

// Frame lengths in bit times
`define BITS_SYNC 4'h8
`define BITS_ASYNC10 4'ha
`define BITS_ASYNC11 4'hb

`endif

// ---- logic/serial_port_zero.v ----
// Notes on behaviour
// (R1) Control bit 7 reads as mode bit or sticky framing-error flag per view select.
// (R2) Mode 00 sync 8-bit, 01 async 10-bit, 10 async 11-bit fixed, 11 async variable.
// (R3) 11-bit modes with filter set: no receive-complete when ninth bit is zero.
// (R4) 10-bit mode with filter set: no receive-complete without a valid stop bit.
// (R5) Sync mode: filter bit picks shift clock, clear divides by 12, set by 4.
// (R6) Reception starts only while the receive-allow bit is one; clearing it aborts async but not sync reception.
// (R7) 11-bit modes transmit the software tx ninth bit as ninth data bit.
// (R8) Rx ninth bit takes ninth bit in 11-bit modes, stop bit in 10-bit unfiltered.
// (R9) Tx-complete sets after 8th bit in sync, at stop start otherwise; software clears.
// (R10) Rx-complete sets after 8th bit in sync, mid stop otherwise; software clears.
// (R11) Data buffer reads the receive register and writes the transmit buffer.
// (R12) Writing the transmit buffer while the shift engine is idle starts a frame in the selected mode.
// (R13) Async receiver starts on a start bit and samples each bit at its centre.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_zero_consts.vh"

module serial_port_zero (
    input wire clk_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire rxd_i,
    output wire rxd_o,
    output wire rxd_oe_o,
    output wire txd_o,
    output wire irq_o
);
    reg mode_hi_r;
    reg mode_lo_r;
    reg filter_r;
    reg rx_allow_r;
    reg tx_ninth_r;
    reg rx_ninth_r;
    reg tx_done_r;
    reg rx_done_r;
    reg frame_err_r;
    reg [7:0] rx_buf_r;
    reg [15:0] baud_r;
    reg view_sel_r;
    reg double_rate_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;
    reg [31:0] prdata_r;
    reg pslverr_r;

    reg rxd_meta_r;
    reg rxd_sync_r;
    reg rxd_prev_r;

    reg tx_busy_r;
    reg sync_rx_r;
    reg [15:0] tx_cnt_r;
    reg [3:0] tx_bits_r;
    reg [10:0] tx_sh_r;
    reg txd_r;
    reg rxd_out_r;
    reg rxd_oe_r;

    localparam RX_IDLE = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA = 2'd2;
    localparam RX_STOP = 2'd3;
    reg [1:0] rx_state_r;
    reg [15:0] rx_cnt_r;
    reg [3:0] rx_bits_r;
    reg [8:0] rx_sh_r;

    wire [1:0] mode = {mode_hi_r, mode_lo_r};
    wire is_sync = (mode == `MODE_SYNC);
    wire is_eleven = mode_hi_r;
    reg [15:0] bit_len;

    // Bit time for the selected mode
    always @* begin
        case (mode)
            `MODE_SYNC: bit_len = filter_r ? `SYNC_DIV_FAST : `SYNC_DIV_SLOW; // R5
            `MODE_ASYNC11_FIXED: bit_len = double_rate_r ? `FIXED_DIV_FAST : `FIXED_DIV_SLOW; // R2
            default: bit_len = baud_r; // R2
        endcase
    end
    wire [15:0] bit_last = bit_len - 16'h0001;
    wire [15:0] half_len = {1'b0, bit_len[15:1]};

    wire wr_acc = psel_i & penable_i & pwrite_i;
    wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
    wire wr_ctl = wr_acc & (paddr_i == `ADDR_CONTROL);
    wire wr_data = wr_acc & (paddr_i == `ADDR_DATA);
    wire wr_stat = wr_acc & (paddr_i == `ADDR_IRQ_STATUS);
    wire mapped = (paddr_i == `ADDR_CONTROL) | (paddr_i == `ADDR_DATA) |
        (paddr_i == `ADDR_BAUD) | (paddr_i == `ADDR_CONFIG) |
        (paddr_i == `ADDR_IRQ_STATUS) | (paddr_i == `ADDR_IRQ_MASK);

    wire [7:0] ctl_view = {view_sel_r ? frame_err_r : mode_hi_r, mode_lo_r, filter_r, // R1
        rx_allow_r, tx_ninth_r, rx_ninth_r, tx_done_r, rx_done_r};

    // Transmit engine events
    wire tx_start = wr_data & ~tx_busy_r; // R12
    // Sync-mode reception is driven by this engine too; it waits for a free line
    wire sync_rx_start = is_sync & rx_allow_r & ~rx_done_r & ~tx_busy_r & ~wr_data; // R6
    wire tx_tick = tx_busy_r & (tx_cnt_r == 16'h0000);
    wire tx_last = tx_tick & (tx_bits_r == 4'h1);
    wire tx_stop_begin = tx_tick & ~is_sync & (tx_bits_r == 4'h2);
    wire sync_sample = tx_busy_r & sync_rx_r & (tx_cnt_r == half_len);
    wire tx_done_set = tx_stop_begin | (tx_last & is_sync & ~sync_rx_r); // R9
    wire sync_rx_done = tx_last & is_sync & sync_rx_r; // R10

    // Async receive events
    wire rx_tick = (rx_cnt_r == 16'h0000);
    wire stop_sample = (rx_state_r == RX_STOP) & rx_tick;
    wire stop_ok = rxd_sync_r;
    wire ninth_rx = rx_sh_r[8];
    reg accept;
    always @* begin
        if (is_eleven) begin
            accept = ~filter_r | ninth_rx; // R3
        end else begin
            accept = ~filter_r | stop_ok; // R4
        end
    end
    wire async_rx_done = stop_sample & accept & ~rx_done_r;
    wire fe_set = stop_sample & ~stop_ok; // R1
    wire rx_done_set = async_rx_done | sync_rx_done; // R10

    // Registers and bus
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode_hi_r <= 1'b0;
            mode_lo_r <= 1'b0;
            filter_r <= 1'b0;
            rx_allow_r <= 1'b0;
            tx_ninth_r <= 1'b0;
            rx_ninth_r <= 1'b0;
            tx_done_r <= 1'b0;
            rx_done_r <= 1'b0;
            frame_err_r <= 1'b0;
            rx_buf_r <= 8'h00;
            baud_r <= `BAUD_DIV_RST;
            view_sel_r <= 1'b0;
            double_rate_r <= 1'b0;
            irq_stat_r <= 3'h0;
            irq_mask_r <= 3'h0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                if (!view_sel_r) begin
                    mode_hi_r <= pwdata_i[`CTL_MODE_HI];
                end
                mode_lo_r <= pwdata_i[`CTL_MODE_LO];
                filter_r <= pwdata_i[`CTL_FILTER];
                rx_allow_r <= pwdata_i[`CTL_RX_ALLOW];
                tx_ninth_r <= pwdata_i[`CTL_TX_NINTH];
            end
            // Hardware sets win over a same-cycle software write
            if (fe_set) begin
                frame_err_r <= 1'b1; // R1
            end else if (wr_ctl & view_sel_r) begin
                frame_err_r <= pwdata_i[`CTL_MODE_HI]; // R1
            end
            if (tx_done_set) begin
                tx_done_r <= 1'b1; // R9
            end else if (wr_ctl) begin
                tx_done_r <= pwdata_i[`CTL_TX_DONE]; // R9
            end
            if (rx_done_set) begin
                rx_done_r <= 1'b1; // R10
            end else if (wr_ctl) begin
                rx_done_r <= pwdata_i[`CTL_RX_DONE]; // R10
            end
            if (async_rx_done) begin
                rx_buf_r <= rx_sh_r[7:0]; // R11
                if (is_eleven) begin
                    rx_ninth_r <= ninth_rx; // R8
                end else if (!filter_r) begin
                    rx_ninth_r <= stop_ok; // R8
                end
            end else if (sync_rx_done) begin
                rx_buf_r <= tx_sh_r[7:0]; // R11
            end else if (wr_ctl) begin
                rx_ninth_r <= pwdata_i[`CTL_RX_NINTH];
            end
            if (wr_acc & (paddr_i == `ADDR_BAUD)) begin
                baud_r <= (pwdata_i[15:0] == 16'h0000) ? 16'h0001 : pwdata_i[15:0];
            end
            if (wr_acc & (paddr_i == `ADDR_CONFIG)) begin
                view_sel_r <= pwdata_i[`CFG_VIEW_SELECT];
                double_rate_r <= pwdata_i[`CFG_DOUBLE_RATE];
            end
            if (wr_acc & (paddr_i == `ADDR_IRQ_MASK)) begin
                irq_mask_r <= pwdata_i[2:0];
            end
            irq_stat_r <= ({fe_set, rx_done_set, tx_done_set}) |
                (irq_stat_r & ~(wr_stat ? pwdata_i[2:0] : 3'h0));
            if (psel_i & ~penable_i) begin
                pslverr_r <= ~mapped;
            end
            if (rd_setup) begin
                case (paddr_i)
                    `ADDR_CONTROL: prdata_r <= {24'h000000, ctl_view};
                    `ADDR_DATA: prdata_r <= {24'h000000, rx_buf_r}; // R11
                    `ADDR_BAUD: prdata_r <= {16'h0000, baud_r};
                    `ADDR_CONFIG: prdata_r <= {30'h00000000, double_rate_r, view_sel_r};
                    `ADDR_IRQ_STATUS: prdata_r <= {29'h00000000, irq_stat_r};
                    `ADDR_IRQ_MASK: prdata_r <= {29'h00000000, irq_mask_r};
                    default: prdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & pslverr_r;
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // Receive line synchroniser
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rxd_meta_r <= 1'b1;
            rxd_sync_r <= 1'b1;
            rxd_prev_r <= 1'b1;
        end else begin
            rxd_meta_r <= rxd_i;
            rxd_sync_r <= rxd_meta_r;
            rxd_prev_r <= rxd_sync_r;
        end
    end

    // Transmit engine, also the shift engine for sync-mode reception
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            tx_busy_r <= 1'b0;
            sync_rx_r <= 1'b0;
            tx_cnt_r <= 16'h0000;
            tx_bits_r <= 4'h0;
            tx_sh_r <= 11'h7ff;
        end else if (tx_start) begin
            tx_busy_r <= 1'b1;
            sync_rx_r <= 1'b0;
            tx_cnt_r <= bit_last;
            case (mode)
                `MODE_SYNC: begin
                    tx_bits_r <= `BITS_SYNC;
                    tx_sh_r <= {3'h7, pwdata_i[7:0]};
                end
                `MODE_ASYNC10: begin
                    tx_bits_r <= `BITS_ASYNC10;
                    tx_sh_r <= {2'h3, pwdata_i[7:0], 1'b0};
                end
                default: begin
                    tx_bits_r <= `BITS_ASYNC11;
                    tx_sh_r <= {1'b1, tx_ninth_r, pwdata_i[7:0], 1'b0}; // R7
                end
            endcase
        end else if (!tx_busy_r) begin
            if (sync_rx_start) begin
                tx_busy_r <= 1'b1; // R6
                sync_rx_r <= 1'b1;
                tx_cnt_r <= bit_last;
                tx_bits_r <= `BITS_SYNC;
                tx_sh_r <= 11'h7ff;
            end
        end else if (tx_tick) begin
            tx_cnt_r <= bit_last;
            if (tx_bits_r == 4'h1) begin
                tx_busy_r <= 1'b0;
                sync_rx_r <= 1'b0;
            end else begin
                tx_bits_r <= tx_bits_r - 4'h1;
                if (!sync_rx_r) begin
                    tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                end
            end
        end else begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
            if (sync_sample) begin
                tx_sh_r <= {3'h7, rxd_sync_r, tx_sh_r[7:1]};
            end
        end
    end

    // Sync mode: shift clock low while the bit counter is above half a bit time, high from there to the end of the bit
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            txd_r <= 1'b1;
            rxd_out_r <= 1'b1;
            rxd_oe_r <= 1'b0;
        end else begin
            if (is_sync) begin
                txd_r <= ~tx_busy_r | (tx_cnt_r <= half_len);
            end else begin
                txd_r <= tx_busy_r ? tx_sh_r[0] : 1'b1;
            end
            rxd_out_r <= tx_sh_r[0];
            rxd_oe_r <= is_sync & tx_busy_r & ~sync_rx_r;
        end
    end

    assign txd_o = txd_r;
    assign rxd_o = rxd_out_r;
    assign rxd_oe_o = rxd_oe_r;

    // Async receiver
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bits_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else if (is_sync | ~rx_allow_r) begin
            rx_state_r <= RX_IDLE; // R6
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    if (rxd_prev_r & ~rxd_sync_r) begin
                        rx_state_r <= RX_START; // R13
                        rx_cnt_r <= half_len;
                    end
                end
                RX_START: begin
                    if (!rx_tick) begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end else if (!rxd_sync_r) begin
                        rx_state_r <= RX_DATA; // R13
                        rx_cnt_r <= bit_last;
                        rx_bits_r <= is_eleven ? 4'h9 : 4'h8;
                        rx_sh_r <= 9'h000;
                    end else begin
                        // Glitch shorter than half a bit is not a start bit
                        rx_state_r <= RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (!rx_tick) begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end else begin
                        rx_cnt_r <= bit_last;
                        rx_bits_r <= rx_bits_r - 4'h1;
                        if (is_eleven) begin
                            rx_sh_r <= {rxd_sync_r, rx_sh_r[8:1]}; // R13
                        end else begin
                            rx_sh_r <= {1'b0, rxd_sync_r, rx_sh_r[7:1]}; // R13
                        end
                        if (rx_bits_r == 4'h1) begin
                            rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (!rx_tick) begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end else begin
                        rx_state_r <= RX_IDLE; // R10
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// ---- verif/serial_port_zero_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_zero_consts.vh"
module serial_port_zero_properties (
    input wire clk_i,
    input wire rst_b_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire rxd_i,
    input wire rxd_o,
    input wire rxd_oe_o,
    input wire txd_o,
    input wire irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire map = paddr_i >= `ADDR_CONTROL && paddr_i <= `ADDR_IRQ_MASK && paddr_i[1:0] == 2'h0;
    wire acc = psel_i && penable_i;
    wire rset = psel_i && !penable_i && !pwrite_i;
    wire wdat = acc && pwrite_i && paddr_i == `ADDR_DATA;
    wire wmsk = acc && pwrite_i && paddr_i == `ADDR_IRQ_MASK && pwdata_i[2:0] == 3'h0;
    ready_high_a: assert property (pready_o)
        else $error("ready low");
    err_unmapped_a: assert property (acc && !map |-> pslverr_o)
        else $error("no error on unmapped access");
    err_mapped_a: assert property (acc && map |-> !pslverr_o)
        else $error("error on mapped access");
    rd_unmapped_a: assert property (rset && !map |=> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (!rset |=> $stable(prdata_o))
        else $error("read data moved");
    rd_width_a: assert property (rset && paddr_i != `ADDR_BAUD |=> prdata_o[31:8] == 24'h0)
        else $error("wide read data");
    irq_mask_a: assert property (wmsk |-> ##2 !irq_o)
        else $error("irq while masked");
    oe_start_a: assert property ($rose(rxd_oe_o) |->
        $past(wdat, 1) || $past(wdat, 2) || $past(wdat, 3) || $past(wdat, 4))
        else $error("pin driven without write");
endmodule
bind serial_port_zero serial_port_zero_properties props (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
`default_nettype wire

// ---- verif/remote_station.sv ----
`timescale 1ns/10ps
`default_nettype none
module remote_station (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic data_i,
    output var logic line_o
);
    initial line_o = 1'b1;
    task automatic send(input logic [10:0] fm, input int n, input int bt);
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= fm[i];
            repeat (bt) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Sync receive: next bit follows each shift clock rise, well before the next sample
    task automatic ssend(input logic [7:0] d);
        line_o <= d[0];
        for (int i = 1; i < 9; i++) begin
            @(posedge line_i);
            line_o <= (i < 8) ? d[i[2:0]] : 1'b1;
        end
    endtask
    // Mid-bit sampling, so a bit time off by half shows up as a wrong bit
    task automatic recv(output logic [10:0] fm, input int n, input int bt);
        fm = 11'h0;
        @(negedge line_i);
        repeat (bt / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            fm[i] = line_i;
            repeat (bt) @(posedge clk_i);
        end
    endtask
    task automatic srecv(output logic [7:0] d, output int per);
        realtime t0;
        for (int i = 0; i < 8; i++) begin
            @(posedge line_i);
            d[i] = data_i;
            if (i == 1) per = int'(($realtime - t0) / 10.0);
            t0 = $realtime;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/serial_port_zero_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_zero_consts.vh"
module serial_port_zero_tb_top;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rdv;
    logic pready_o, pslverr_o, rxd_o, rxd_oe_o, txd_o, irq_o, line;
    wire rxd_i = rxd_oe_o ? rxd_o : line;
    logic [10:0] fr;
    logic [7:0] sd;
    int per, failures = 0, compares = 0;
    always #5 clk_i = ~clk_i;
    serial_port_zero dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i),
        .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
    remote_station rs (.clk_i(clk_i), .line_i(txd_o), .data_i(rxd_o), .line_o(line));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // No fixed latency assumed: the request stands until pready is seen
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rdv = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    function automatic logic [31:0] cv(input logic [1:0] m, input logic f, en, tb);
        return {24'h0, m, f, en, tb, 3'h0};
    endfunction
    task automatic t_tx();
        bus(1'b0, `ADDR_BAUD, 32'h0);
        chk(rdv, 32'h364);
        bus(1'b0, 12'h3fc, 32'h0);
        chk(rdv, 32'h0);
        bus(1'b1, `ADDR_BAUD, 32'h10);
        bus(1'b1, `ADDR_CONTROL, cv(2'h1, 1'b0, 1'b0, 1'b0));
        fork
            rs.recv(fr, 10, 16);
            begin
                bus(1'b1, `ADDR_DATA, 32'ha5);
                bus(1'b1, `ADDR_DATA, 32'h00);
                bus(1'b0, `ADDR_CONTROL, 32'h0);
                chk(rdv[1], 1'b0);
            end
        join
        chk(fr, {1'b0, 1'b1, 8'ha5, 1'b0});
        bus(1'b0, `ADDR_CONTROL, 32'h0);
        chk(rdv[1], 1'b1);
        bus(1'b1, `ADDR_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1);
        bus(1'b1, `ADDR_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
        bus(1'b1, `ADDR_IRQ_STATUS, 32'h1);
        bus(1'b1, `ADDR_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b0);
        $display("tx test done");
    endtask
    task automatic t_ninth();
        logic b;
        int bt;
        for (int k = 0; k < 4; k++) begin
            b = k[0];
            bt = k == 2 ? 64 : k == 3 ? 32 : 16;
            bus(1'b1, `ADDR_CONFIG, k == 3 ? 32'h2 : 32'h0);
            bus(1'b1, `ADDR_CONTROL, cv(k < 2 ? 2'h3 : 2'h2, 1'b0, 1'b0, b));
            fork
                rs.recv(fr, 11, bt);
                bus(1'b1, `ADDR_DATA, 32'h5a + k);
            join
            chk(fr, {1'b1, b, 8'h5a + 8'(k), 1'b0});
        end
        bus(1'b1, `ADDR_CONFIG, 32'h0);
        $display("ninth bit test done");
    endtask
    task automatic rx_case(input logic [1:0] m, input logic f, en, input logic [10:0] fm,
        input int n, input logic done);
        bus(1'b1, `ADDR_CONTROL, cv(m, f, en, 1'b0));
        rs.send(fm, n, m == 2'h2 ? 64 : 16);
        repeat (8) @(posedge clk_i);
        bus(1'b0, `ADDR_CONTROL, 32'h0);
        chk(rdv[0], done);
        if (done) begin
            chk(rdv[2], fm[9]);
            bus(1'b0, `ADDR_DATA, 32'h0);
            chk(rdv, {24'h0, fm[8:1]});
        end
    endtask
    task automatic t_rx();
        rx_case(2'h1, 1'b0, 1'b1, {1'b1, 8'h96, 1'b0}, 10, 1'b1);
        rx_case(2'h1, 1'b0, 1'b0, {1'b1, 8'h69, 1'b0}, 10, 1'b0);
        bus(1'b1, `ADDR_CONFIG, 32'h1);
        rx_case(2'h1, 1'b1, 1'b1, {1'b0, 8'h96, 1'b0}, 10, 1'b0);
        chk(rdv[7], 1'b1);
        bus(1'b1, `ADDR_CONTROL, 32'h0);
        bus(1'b0, `ADDR_CONTROL, 32'h0);
        chk(rdv[7], 1'b0);
        bus(1'b1, `ADDR_CONFIG, 32'h0);
        rx_case(2'h3, 1'b1, 1'b1, {2'h2, 8'h33, 1'b0}, 11, 1'b0);
        rx_case(2'h3, 1'b1, 1'b1, {2'h3, 8'hc7, 1'b0}, 11, 1'b1);
        rx_case(2'h2, 1'b0, 1'b1, {2'h2, 8'h0f, 1'b0}, 11, 1'b1);
        $display("rx test done");
    endtask
    task automatic t_sync();
        for (int f = 0; f < 2; f++) begin
            bus(1'b1, `ADDR_CONTROL, cv(2'h0, f[0], 1'b0, 1'b0));
            fork
                rs.srecv(sd, per);
                bus(1'b1, `ADDR_DATA, 32'hc3 ^ f);
            join
            chk(sd, 8'hc3 ^ 8'(f));
            chk(per, f ? 4 : 12);
            repeat (16) @(posedge clk_i);
            bus(1'b0, `ADDR_CONTROL, 32'h0);
            chk(rdv[1], 1'b1);
        end
        $display("sync test done");
    endtask
    // Sync-mode reception at both shift clocks, started by allowing reception
    task automatic t_srx();
        for (int f = 0; f < 2; f++) begin
            fork
                rs.ssend(8'h9c ^ 8'(f));
                bus(1'b1, `ADDR_CONTROL, cv(2'h0, f[0], 1'b1, 1'b0));
            join
            repeat (8) @(posedge clk_i);
            bus(1'b0, `ADDR_CONTROL, 32'h0);
            chk(rdv[0], 1'b1);
            bus(1'b0, `ADDR_DATA, 32'h0);
            chk(rdv, 32'h9c ^ f);
        end
        bus(1'b1, `ADDR_CONTROL, 32'h0);
        $display("sync receive test done");
    endtask
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_tx();
        t_ninth();
        t_rx();
        t_sync();
        t_srx();
        conclude();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
